// ---- rtl/asf_pkg.sv ----
// package: constants and types for the alu status flag block
package asf_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 12;
   // register map of this block's own port
   localparam logic [11:0] FLAGS_ADDR = 12'hfd8;
   localparam logic [11:0] CFG_ADDR = 12'hfd0;
   // flag positions
   localparam int NEG_BIT = 4;
   localparam int OVF_BIT = 3;
   localparam int ZERO_BIT = 2;
   localparam int NIB_BIT = 1;
   localparam int CARRY_BIT = 0;
   localparam int FLAG_W = 5;
   localparam logic [7:0] FLAG_MASK = 8'h1f;
   localparam logic [4:0] FLAG_RESET = 5'h00;
   localparam logic [0:0] EXT_ISA_RESET = 1'h0;
   localparam int LO_NIB_TOP = 3;
   localparam int HI_NIB_BIT = 4;
   localparam int SIGN_BIT = 7;

   typedef enum logic [3:0] {
      ASF_OP_NONE = 4'h0,
      ASF_OP_ADDF = 4'h1,
      ASF_OP_ADDL = 4'h2,
      ASF_OP_SUBL = 4'h3,
      ASF_OP_SUBF = 4'h4,
      ASF_OP_RRC = 4'h5,
      ASF_OP_RLC = 4'h6,
      ASF_OP_LOGIC = 4'h7,
      ASF_OP_CLR = 4'h8,
      ASF_OP_MOVE = 4'h9,
      ASF_OP_BSET = 4'ha,
      ASF_OP_BCLR = 4'hb,
      ASF_OP_SWAP = 4'hc
   } asf_op_e;

   typedef enum logic [1:0] {
      ASF_AM_INHERENT = 2'h0,
      ASF_AM_LITERAL = 2'h1,
      ASF_AM_DIRECT = 2'h2,
      ASF_AM_INDEXED = 2'h3
   } asf_am_e;

   typedef struct packed {
      asf_op_e op;
      logic [7:0] a;
      logic [7:0] b;
      logic [2:0] bitsel;
      logic [11:0] dest;
      logic dest_file;
      asf_am_e mode;
   } asf_req_s;

   typedef struct packed {
      logic [7:0] res;
      logic [4:0] upd;
      logic [4:0] val;
   } asf_alu_s;
endpackage

// ---- rtl/asf_adder.sv ----
// 8-bit adder with nibble and top carries
`timescale 1ns/100ps
module asf_adder #(
   parameter int W = 8
) (
   input wire logic [W-1:0] a,
   input wire logic [W-1:0] b,
   input wire logic cin,
   output logic [W-1:0] sum,
   output logic c_nib,
   output logic c_top,
   output logic ovf
);
   logic [4:0] lo;
   logic [W-4:0] hi;
   always_comb begin
      lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      hi = {1'b0, a[W-1:4]} + {1'b0, b[W-1:4]} + {{(W-4){1'b0}}, lo[4]};
      sum = {hi[W-5:0], lo[3:0]};
      c_nib = lo[4];
      c_top = hi[W-4];
      // sign flips although operands share sign
      ovf = (a[W-1] == b[W-1]) && (sum[W-1] != a[W-1]);
   end
endmodule // asf_adder

// ---- rtl/asf_flag_alu.sv ----
// result and flag computation for one instruction
`timescale 1ns/100ps
module asf_flag_alu (
   input wire asf_pkg::asf_req_s req,
   input wire logic carry_in,
   output asf_pkg::asf_alu_s out
);
   logic [7:0] add_b;
   logic [7:0] add_a;
   logic [7:0] sum;
   logic c_nib;
   logic c_top;
   logic ovf;

   always_comb begin
      add_a = req.a;
      add_b = req.b;
      // subtract adds the two's complement of the second operand
      if (req.op == asf_pkg::ASF_OP_SUBL || req.op == asf_pkg::ASF_OP_SUBF) begin
         add_b = ~req.b;
      end
   end

   asf_adder #(.W(8)) u_add (
      .a(add_a),
      .b(add_b),
      .cin(req.op == asf_pkg::ASF_OP_SUBL || req.op == asf_pkg::ASF_OP_SUBF),
      .sum(sum),
      .c_nib(c_nib),
      .c_top(c_top),
      .ovf(ovf)
   );

   always_comb begin
      out.res = 8'h00;
      out.upd = 5'h00;
      out.val = 5'h00;
      case (req.op)
         asf_pkg::ASF_OP_ADDF, asf_pkg::ASF_OP_ADDL,
         asf_pkg::ASF_OP_SUBL, asf_pkg::ASF_OP_SUBF: begin
            out.res = sum;
            out.upd = 5'h1f;
            out.val[asf_pkg::NEG_BIT] = sum[asf_pkg::SIGN_BIT];
            out.val[asf_pkg::OVF_BIT] = ovf;
            out.val[asf_pkg::ZERO_BIT] = (sum == 8'h00);
            out.val[asf_pkg::NIB_BIT] = c_nib;
            out.val[asf_pkg::CARRY_BIT] = c_top;
         end
         asf_pkg::ASF_OP_RRC: begin
            out.res = {carry_in, req.a[7:1]};
            // rotates leave the overflow flag alone
            out.upd = 5'h17;
            out.val[asf_pkg::NEG_BIT] = carry_in;
            out.val[asf_pkg::ZERO_BIT] = ({carry_in, req.a[7:1]} == 8'h00);
            out.val[asf_pkg::NIB_BIT] = req.a[asf_pkg::HI_NIB_BIT];
            out.val[asf_pkg::CARRY_BIT] = req.a[0];
         end
         asf_pkg::ASF_OP_RLC: begin
            out.res = {req.a[6:0], carry_in};
            out.upd = 5'h17;
            out.val[asf_pkg::NEG_BIT] = req.a[6];
            out.val[asf_pkg::ZERO_BIT] = ({req.a[6:0], carry_in} == 8'h00);
            out.val[asf_pkg::NIB_BIT] = req.a[asf_pkg::LO_NIB_TOP];
            out.val[asf_pkg::CARRY_BIT] = req.a[7];
         end
         asf_pkg::ASF_OP_LOGIC: begin
            out.res = req.a & req.b;
            out.upd = 5'h14;
            out.val[asf_pkg::NEG_BIT] = out.res[asf_pkg::SIGN_BIT];
            out.val[asf_pkg::ZERO_BIT] = (out.res == 8'h00);
         end
         asf_pkg::ASF_OP_CLR: begin
            out.res = 8'h00;
            out.upd = 5'h04;
            out.val[asf_pkg::ZERO_BIT] = 1'b1;
         end
         asf_pkg::ASF_OP_MOVE: begin
            out.res = req.a;
         end
         asf_pkg::ASF_OP_BSET: begin
            out.res = req.a | (8'h01 << req.bitsel);
         end
         asf_pkg::ASF_OP_BCLR: begin
            out.res = req.a & ~(8'h01 << req.bitsel);
         end
         asf_pkg::ASF_OP_SWAP: begin
            out.res = {req.a[3:0], req.a[7:4]};
         end
         default: begin
            out.res = 8'h00;
         end
      endcase
   end
endmodule // asf_flag_alu

// ---- rtl/asf_status.sv ----
// alu status flag register with decoder, alu and software port
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/100ps
module asf_status (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic exec_valid,
   input wire asf_pkg::asf_req_s exec_req,
   input wire logic [11:0] sw_addr,
   input wire logic [7:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [7:0] sw_rdata,
   output logic [7:0] exec_result,
   output logic exec_result_wr,
   output logic exec_mode_err,
   output logic [7:0] alu_flags,
   output logic extended_isa_enable
);
   asf_pkg::asf_alu_s alu_out;
   logic [4:0] flags_r;
   logic [4:0] flags_nxt;
   logic ext_isa_r;
   logic flags_seen_r;
   logic [7:0] rdata_r;
   logic [7:0] result_r;
   logic result_wr_r;
   logic mode_err_r;
   logic to_flags;
   logic mode_ok;
   logic go;

   asf_flag_alu u_alu (
      .req(exec_req),
      .carry_in(flags_r[asf_pkg::CARRY_BIT]),
      .out(alu_out)
   );

   // indexed mode only with the extended isa bit set
   assign mode_ok = (exec_req.mode != asf_pkg::ASF_AM_INDEXED) || ext_isa_r;
   assign go = exec_valid && mode_ok;
   assign to_flags = exec_req.dest_file && (exec_req.dest == asf_pkg::FLAGS_ADDR);

   always_comb begin
      flags_nxt = flags_r;
      if (go) begin
         // per-bit merge: untouched flags keep their value
         flags_nxt = (flags_r & ~alu_out.upd) | (alu_out.val & alu_out.upd);
         if (to_flags && alu_out.upd == 5'h00) begin
            // non-flag ops write their result straight into the flags
            flags_nxt = alu_out.res[4:0];
         end
      end else if (sw_wr && sw_addr == asf_pkg::FLAGS_ADDR) begin
         flags_nxt = sw_wdata[4:0];
      end
   end

   // flags have no reset value, matching the unknown power-up state
   always_ff @(posedge core_clk) begin
      if (clk_en) begin
         flags_r <= flags_nxt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ext_isa_r <= asf_pkg::EXT_ISA_RESET;
      end else if (clk_en && sw_wr && sw_addr == asf_pkg::CFG_ADDR) begin
         ext_isa_r <= sw_wdata[0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         result_r <= 8'h00;
         result_wr_r <= 1'b0;
         mode_err_r <= 1'b0;
      end else if (clk_en) begin
         result_r <= alu_out.res;
         // result dropped when a flag-changing op targets the flags
         result_wr_r <= go && !(to_flags && alu_out.upd != 5'h00);
         mode_err_r <= exec_valid && !mode_ok;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdata_r <= 8'h00;
      end else if (clk_en) begin
         rdata_r <= 8'h00;
         if (sw_rd) begin
            if (sw_addr == asf_pkg::FLAGS_ADDR) begin
               rdata_r <= {3'h0, flags_r};
            end else if (sw_addr == asf_pkg::CFG_ADDR) begin
               rdata_r <= {7'h00, ext_isa_r};
            end else begin
               rdata_r <= 8'h00;
            end
         end
      end
   end

   assign sw_rdata = rdata_r;
   assign exec_result = result_r;
   assign exec_result_wr = result_wr_r;
   assign exec_mode_err = mode_err_r;
   assign alu_flags = {3'h0, flags_r};
   assign extended_isa_enable = ext_isa_r;

   // checks only: flags hold no defined value until software first writes them
   always_ff @(posedge core_clk) begin
      if (rst) begin
         flags_seen_r <= 1'b0;
      end else if (clk_en && sw_wr && sw_addr == asf_pkg::FLAGS_ADDR) begin
         flags_seen_r <= 1'b1;
      end
   end

   a_clr_sets_zero: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && go && exec_req.op == asf_pkg::ASF_OP_CLR |=>
      alu_flags[2] && alu_flags[4:3] == $past(alu_flags[4:3])
      && alu_flags[1:0] == $past(alu_flags[1:0]))
      else $error("clear did not set only zero");
   a_top_bits_zero: assert property (@(posedge core_clk) disable iff (rst)
      sw_rd && clk_en |=> sw_rdata[7:5] == 3'h0)
      else $error("upper bits not zero");
   a_add_carry: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && go && exec_req.op == asf_pkg::ASF_OP_ADDL |=>
      alu_flags[0] == $past((9'(exec_req.a) + 9'(exec_req.b)) > 9'h0ff))
      else $error("add carry wrong");
   a_sub_borrow: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && go && exec_req.op == asf_pkg::ASF_OP_SUBF |=>
      alu_flags[0] == $past(exec_req.a >= exec_req.b))
      else $error("sub borrow polarity wrong");
   a_nib_carry: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && go && exec_req.op == asf_pkg::ASF_OP_ADDF |=>
      alu_flags[1] == $past((5'(exec_req.a[3:0]) + 5'(exec_req.b[3:0])) > 5'h0f))
      else $error("nibble carry wrong");
   a_zero_flag: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && go && exec_req.op == asf_pkg::ASF_OP_ADDF |=>
      alu_flags[2] == $past(exec_req.a + exec_req.b == 8'h00))
      else $error("zero flag wrong");
   a_rot_left: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && go && exec_req.op == asf_pkg::ASF_OP_RLC |=>
      alu_flags[0] == $past(exec_req.a[7]) && alu_flags[1] == $past(exec_req.a[3]))
      else $error("rotate left flags wrong");
   a_rot_right: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && go && exec_req.op == asf_pkg::ASF_OP_RRC |=>
      alu_flags[0] == $past(exec_req.a[0]) && alu_flags[1] == $past(exec_req.a[4]))
      else $error("rotate right flags wrong");
   a_drop_result: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && go && to_flags && exec_req.op == asf_pkg::ASF_OP_ADDF |=> !exec_result_wr)
      else $error("result written to flags");
   a_index_gate: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && exec_valid && exec_req.mode == asf_pkg::ASF_AM_INDEXED && !ext_isa_r
      |=> exec_mode_err && !exec_result_wr)
      else $error("indexed mode not refused");

   sequence s_sw_flag_wr;
      clk_en && sw_wr && sw_addr == asf_pkg::FLAGS_ADDR && !go;
   endsequence
   sequence s_frozen;
      !clk_en && flags_seen_r;
   endsequence
   sequence s_rotate;
      clk_en && go && flags_seen_r
      && (exec_req.op == asf_pkg::ASF_OP_RRC || exec_req.op == asf_pkg::ASF_OP_RLC);
   endsequence
   sequence s_add_to_file;
      clk_en && go && !to_flags
      && (exec_req.op == asf_pkg::ASF_OP_ADDF || exec_req.op == asf_pkg::ASF_OP_ADDL);
   endsequence

   a_sw_flag_write: assert property (@(posedge core_clk) disable iff (rst)
      s_sw_flag_wr |=> alu_flags == {3'h0, $past(sw_wdata[4:0])})
      else $error("software flag write lost");
   // the op must win over a software write in the same cycle
   a_op_beats_write: assert property (@(posedge core_clk) disable iff (rst)
      s_add_to_file ##0 (sw_wr && sw_addr == asf_pkg::FLAGS_ADDR)
      |=> alu_flags[2] == (exec_result == 8'h00) && alu_flags[4] == exec_result[7])
      else $error("software write beat the op");
   a_neg_flag: assert property (@(posedge core_clk) disable iff (rst)
      s_add_to_file |=> alu_flags[4] == exec_result[7]
      && exec_result == $past(exec_req.a) + $past(exec_req.b))
      else $error("negative flag wrong");
   a_ovf_flag: assert property (@(posedge core_clk) disable iff (rst)
      s_add_to_file |=> alu_flags[3] == ($past(exec_req.a[7]) == $past(exec_req.b[7])
      && exec_result[7] != $past(exec_req.a[7])))
      else $error("overflow flag wrong");
   a_rot_keeps_ovf: assert property (@(posedge core_clk) disable iff (rst)
      s_rotate |=> alu_flags[3] == $past(alu_flags[3]))
      else $error("rotate changed overflow");
   a_freeze: assert property (@(posedge core_clk) disable iff (rst)
      s_frozen |=> alu_flags == $past(alu_flags) && exec_result == $past(exec_result)
      && extended_isa_enable == $past(extended_isa_enable))
      else $error("state moved with enable low");
   a_logic_keeps: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && go && flags_seen_r && exec_req.op == asf_pkg::ASF_OP_LOGIC |=>
      alu_flags[3] == $past(alu_flags[3]) && alu_flags[1:0] == $past(alu_flags[1:0])
      && alu_flags[2] == ($past(exec_req.a & exec_req.b) == 8'h00))
      else $error("logic op flags wrong");
   a_refused_hold: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && exec_valid && !mode_ok && flags_seen_r && !sw_wr |=>
      alu_flags == $past(alu_flags))
      else $error("refused op changed flags");
   a_sub_nibble: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && go && exec_req.op == asf_pkg::ASF_OP_SUBL |=>
      alu_flags[1] == $past(exec_req.a[3:0] >= exec_req.b[3:0]))
      else $error("nibble borrow polarity wrong");
   a_rdata_pulse: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && !sw_rd |=> sw_rdata == 8'h00)
      else $error("read data outlived its cycle");
   a_cfg_read: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && sw_rd && sw_addr == asf_pkg::CFG_ADDR |=>
      sw_rdata == {7'h00, $past(extended_isa_enable)})
      else $error("config read wrong");
   a_move_to_flags: assert property (@(posedge core_clk) disable iff (rst)
      clk_en && go && to_flags && exec_req.op == asf_pkg::ASF_OP_MOVE |=>
      alu_flags == {3'h0, $past(exec_req.a[4:0])})
      else $error("move into flags lost");
endmodule // asf_status

// ---- verif/testbench.sv ----
// self-checking bench for the alu status flag block
`timescale 1ns/100ps
module testbench;
   logic core_clk, rst, clk_en, exec_valid, sw_wr, sw_rd;
   asf_pkg::asf_req_s exec_req;
   logic [11:0] sw_addr;
   logic [7:0] sw_wdata, sw_rdata, exec_result, alu_flags;
   logic exec_result_wr, exec_mode_err, extended_isa_enable;
   logic [4:0] ef;
   logic xi;
   int n_errors, checks_done, i;
   int seed = 32'hd5ae3f88;

   asf_status i_asf_status (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
      .exec_valid(exec_valid), .exec_req(exec_req), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
      .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .exec_result(exec_result),
      .exec_result_wr(exec_result_wr), .exec_mode_err(exec_mode_err), .alu_flags(alu_flags),
      .extended_isa_enable(extended_isa_enable));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic end_of_test();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // returns {result, neg, ovf, zero, nib, carry}; subtract adds the inverted operand plus one
   function automatic logic [12:0] calc(asf_pkg::asf_op_e op, logic [7:0] a, logic [7:0] b,
                                        logic [2:0] s, logic [4:0] f);
      logic [8:0] t;
      logic [4:0] lo;
      logic [7:0] r, bb;
      logic sb;
      logic [4:0] g;
      g = f;
      sb = (op == asf_pkg::ASF_OP_SUBL || op == asf_pkg::ASF_OP_SUBF);
      bb = sb ? ~b : b;
      r = a;
      case (op)
         asf_pkg::ASF_OP_ADDF, asf_pkg::ASF_OP_ADDL, asf_pkg::ASF_OP_SUBL,
         asf_pkg::ASF_OP_SUBF: begin
            t = {1'b0, a} + {1'b0, bb} + {8'h00, sb};
            lo = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sb};
            r = t[7:0];
            g = {r[7], (a[7] == bb[7]) && (r[7] != a[7]), r == 8'h00, lo[4], t[8]};
         end
         asf_pkg::ASF_OP_RRC: begin
            r = {f[0], a[7:1]};
            g = {r[7], f[3], r == 8'h00, a[4], a[0]};
         end
         asf_pkg::ASF_OP_RLC: begin
            r = {a[6:0], f[0]};
            g = {r[7], f[3], r == 8'h00, a[3], a[7]};
         end
         asf_pkg::ASF_OP_LOGIC: begin
            r = a & b;
            g = {r[7], f[3], r == 8'h00, f[1:0]};
         end
         asf_pkg::ASF_OP_CLR: begin
            r = 8'h00;
            g = {f[4:3], 1'b1, f[1:0]};
         end
         asf_pkg::ASF_OP_BSET: r = a | (8'h01 << s);
         asf_pkg::ASF_OP_BCLR: r = a & ~(8'h01 << s);
         asf_pkg::ASF_OP_SWAP: r = {a[3:0], a[7:4]};
         default: r = a;
      endcase
      return {r, g};
   endfunction

   task automatic sw(input logic w, input logic [11:0] ad, input logic [7:0] d,
                     input logic [7:0] e);
      @(posedge core_clk);
      sw_wr <= w;
      sw_rd <= !w;
      sw_addr <= ad;
      sw_wdata <= d;
      @(posedge core_clk);
      sw_wr <= 1'b0;
      sw_rd <= 1'b0;
      #1;
      if (!w) cmp8("sw_rdata", e, sw_rdata);
   endtask

   task automatic ex(input asf_pkg::asf_op_e op, input logic [7:0] a, input logic [7:0] b,
                     input logic [11:0] dst, input asf_pkg::asf_am_e md);
      asf_pkg::asf_req_s r;
      logic [12:0] c;
      logic fl, bad, nf;
      r.op = op;
      r.a = a;
      r.b = b;
      r.bitsel = a[2:0] ^ b[2:0];
      r.dest = dst;
      r.dest_file = !(a[7] && b[0]);
      r.mode = md;
      c = calc(op, a, b, r.bitsel, ef);
      fl = (dst == asf_pkg::FLAGS_ADDR) && r.dest_file;
      bad = (md == asf_pkg::ASF_AM_INDEXED) && !xi;
      nf = op inside {asf_pkg::ASF_OP_MOVE, asf_pkg::ASF_OP_BSET, asf_pkg::ASF_OP_BCLR,
                      asf_pkg::ASF_OP_SWAP};
      @(posedge core_clk);
      exec_valid <= 1'b1;
      exec_req <= r;
      @(posedge core_clk);
      exec_valid <= 1'b0;
      #1;
      cmp8("exec_mode_err", {7'h00, bad}, {7'h00, exec_mode_err});
      if (!bad) begin
         ef = (fl && nf) ? c[9:5] : c[4:0];
         if (!fl) cmp8("exec_result", c[12:5], exec_result);
         if (!(fl && nf)) cmp8("exec_result_wr", {7'h00, !fl}, {7'h00, exec_result_wr});
      end
      cmp8("flags", {3'h0, ef}, alu_flags);
   endtask

   initial begin
      #200000;
      n_errors++;
      end_of_test();
   end

   initial begin
      rst = 1'b1;
      clk_en = 1'b1;
      exec_valid = 1'b0;
      exec_req = '0;
      sw_addr = 12'h000;
      sw_wdata = 8'h00;
      sw_wr = 1'b0;
      sw_rd = 1'b0;
      n_errors = 0;
      checks_done = 0;
      xi = 1'b0;
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      cmp8("isa_enable", 8'h00, {7'h00, extended_isa_enable});
      sw(1'b1, asf_pkg::FLAGS_ADDR, 8'hff, 8'h00);
      sw(1'b0, asf_pkg::FLAGS_ADDR, 8'h00, 8'h1f);
      ef = 5'h1f;
      sw(1'b0, 12'h123, 8'h00, 8'h00);
      // fixed corners: nibble carry, signed overflow, wrap to zero, borrows
      ex(asf_pkg::ASF_OP_ADDL, 8'h0f, 8'h01, 12'h020, asf_pkg::ASF_AM_LITERAL);
      ex(asf_pkg::ASF_OP_ADDF, 8'h7f, 8'h01, 12'h020, asf_pkg::ASF_AM_DIRECT);
      ex(asf_pkg::ASF_OP_ADDF, 8'hff, 8'h01, 12'h020, asf_pkg::ASF_AM_DIRECT);
      ex(asf_pkg::ASF_OP_SUBF, 8'h00, 8'h01, 12'h020, asf_pkg::ASF_AM_DIRECT);
      ex(asf_pkg::ASF_OP_SUBL, 8'h10, 8'h01, 12'h020, asf_pkg::ASF_AM_LITERAL);
      ex(asf_pkg::ASF_OP_SUBF, 8'h05, 8'h05, asf_pkg::FLAGS_ADDR, asf_pkg::ASF_AM_DIRECT);
      ex(asf_pkg::ASF_OP_RLC, 8'h88, 8'h00, 12'h020, asf_pkg::ASF_AM_DIRECT);
      ex(asf_pkg::ASF_OP_RRC, 8'h11, 8'h00, 12'h020, asf_pkg::ASF_AM_DIRECT);
      ex(asf_pkg::ASF_OP_CLR, 8'h5a, 8'h00, asf_pkg::FLAGS_ADDR, asf_pkg::ASF_AM_DIRECT);
      ex(asf_pkg::ASF_OP_MOVE, 8'hff, 8'h00, asf_pkg::FLAGS_ADDR, asf_pkg::ASF_AM_DIRECT);
      // indexed mode refused until the extended isa bit is set
      ex(asf_pkg::ASF_OP_ADDF, 8'h01, 8'h02, 12'h020, asf_pkg::ASF_AM_INDEXED);
      sw(1'b1, asf_pkg::CFG_ADDR, 8'h01, 8'h00);
      xi = 1'b1;
      sw(1'b0, asf_pkg::CFG_ADDR, 8'h00, 8'h01);
      ex(asf_pkg::ASF_OP_ADDF, 8'h01, 8'h02, 12'h020, asf_pkg::ASF_AM_INDEXED);
      sw(1'b1, asf_pkg::CFG_ADDR, 8'h00, 8'h00);
      xi = 1'b0;
      // enable low freezes a pending op; then op and flag write in one cycle, the op wins
      @(posedge core_clk);
      clk_en <= 1'b0;
      exec_valid <= 1'b1;
      exec_req <= '{asf_pkg::ASF_OP_ADDF, 8'hff, 8'h01, 3'h0, 12'h020, 1'b1,
                    asf_pkg::ASF_AM_DIRECT};
      sw_wr <= 1'b1;
      sw_addr <= asf_pkg::FLAGS_ADDR;
      sw_wdata <= 8'hff;
      repeat (3) @(posedge core_clk);
      #1;
      cmp8("frozen_flags", {3'h0, ef}, alu_flags);
      @(posedge core_clk);
      clk_en <= 1'b1;
      @(posedge core_clk);
      exec_valid <= 1'b0;
      sw_wr <= 1'b0;
      ef = 5'h07;
      #1;
      cmp8("op_wins_flags", {3'h0, ef}, alu_flags);
      cmp8("op_wins_result", 8'h00, exec_result);
      for (i = 0; i < 400; i++) begin
         ex(asf_pkg::asf_op_e'(4'h1 + 4'($unsigned($random(seed)) % 12)), 8'($random(seed)),
            8'($random(seed)), ($random(seed) & 1) ? asf_pkg::FLAGS_ADDR : 12'h020,
            asf_pkg::asf_am_e'(2'($unsigned($random(seed)) % 4)));
         if (i % 50 == 0) sw(1'b0, asf_pkg::FLAGS_ADDR, 8'h00, {3'h0, ef});
      end
      end_of_test();
   end
endmodule // testbench
